// >>> design/mpd_cmd_decoder.sv
// Command decoder and drive pulse scheduler with APB status/control
`timescale 1ns/1ps
`default_nettype none
module mpd_cmd_decoder #(
   parameter int GAP_CYC = mpd_pkg::GAP_CYC,
   parameter int MS_CYC = mpd_pkg::MS_CYC,
   parameter logic [3:0] FW_MAJOR = 4'h1,
   parameter logic [3:0] FW_MINOR = 4'h2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic iface_sel_bit0,
   input wire logic iface_sel_bit1,
   input wire logic step_in,
   input wire logic dir_in,
   input wire logic idle_in_n,
   input wire logic adc_valid,
   input wire logic [7:0] adc_code,
   input wire logic temp_valid,
   input wire logic [7:0] temp_code,
   output logic pulse_out,
   output logic pulse_cw,
   output logic green_led,
   output logic red_led,
   output logic fault_out_n
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [4:0] sync1_r;
   logic [4:0] sync2_r;
   logic a_d_r;
   logic b_d_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 5'h10;
         sync2_r <= 5'h10;
         a_d_r <= 1'b0;
         b_d_r <= 1'b0;
      end else begin
         sync1_r <= {idle_in_n, iface_sel_bit1, iface_sel_bit0, step_in, dir_in};
         sync2_r <= sync1_r;
         a_d_r <= sync2_r[0];
         b_d_r <= sync2_r[1];
      end
   end
   logic a_s;
   logic b_s;
   logic idle_s;
   assign a_s = sync2_r[0];
   assign b_s = sync2_r[1];
   assign idle_s = sync2_r[4];

   // ****************************************
   // Mode latch, once after reset release
   // ****************************************
   logic [1:0] lock_cnt_r;
   logic lock_r;
   mpd_pkg::mpd_mode_t mode_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_cnt_r <= 2'h0;
         lock_r <= 1'b0;
         mode_r <= mpd_pkg::MD_STEP;
      end else if (!lock_r) begin
         lock_cnt_r <= lock_cnt_r + 2'h1;
         // Wait for the strap synchronisers to fill
         if (lock_cnt_r == mpd_pkg::LOCK_WAIT) begin
            lock_r <= 1'b1;
            case (sync2_r[3:2])
               2'h0: mode_r <= mpd_pkg::MD_STEP;
               2'h1: mode_r <= mpd_pkg::MD_QUAD;
               2'h2: mode_r <= mpd_pkg::MD_LIN;
               default: mode_r <= mpd_pkg::MD_BANG;
            endcase
         end
      end
   end

   // ****************************************
   // Digital command events
   // ****************************************
   logic step_ev;
   logic ea;
   logic eb;
   logic qa_ok;
   logic qb_ok;
   logic qlast_b_r;
   logic qany_r;
   assign step_ev = (mode_r == mpd_pkg::MD_STEP) && b_d_r && !b_s;
   assign ea = (mode_r == mpd_pkg::MD_QUAD) && (a_s != a_d_r);
   assign eb = (mode_r == mpd_pkg::MD_QUAD) && (b_s != b_d_r);
   assign qa_ok = ea && (!qany_r || qlast_b_r);
   // Simultaneous edges: phase A wins unless the last edge taken was on A, then B wins
   assign qb_ok = eb && !qa_ok && (!qany_r || !qlast_b_r);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qany_r <= 1'b0;
         qlast_b_r <= 1'b0;
      end else if (qa_ok || qb_ok) begin
         qany_r <= 1'b1;
         qlast_b_r <= qb_ok;
      end
   end

   // ****************************************
   // Analog rate generator
   // ****************************************
   localparam logic [31:0] ACC_TOP = 32'(int'(mpd_pkg::ANA_FULL) * GAP_CYC);
   logic [7:0] code_r;
   logic [8:0] mag;
   logic [8:0] inc;
   logic [31:0] acc_r;
   logic [31:0] acc_sum;
   logic ana_ev;
   assign mag = code_r[7] ? (9'h000 - {1'b1, code_r}) : {1'b0, code_r};
   always_comb begin
      inc = 9'h000;
      if (mag > mpd_pkg::DB_CODE) begin
         if (mode_r == mpd_pkg::MD_LIN)
            inc = mag;
         else if (mode_r == mpd_pkg::MD_BANG)
            inc = mpd_pkg::ANA_FULL;
      end
   end
   assign acc_sum = acc_r + {23'h0, inc};
   assign ana_ev = lock_r && (acc_sum >= ACC_TOP);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         code_r <= 8'h00;
      else if (adc_valid)
         code_r <= adc_code;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         acc_r <= 32'h0;
      else if (inc == 9'h000)
         acc_r <= 32'h0;
      else if (ana_ev)
         acc_r <= acc_sum - ACC_TOP;
      else
         acc_r <= acc_sum;
   end

   // ****************************************
   // Pending request and direction
   // ****************************************
   logic ev;
   logic ev_cw;
   logic pend_r;
   logic pend_cw_r;
   logic fire;
   assign ev = lock_r && idle_s && (step_ev || qa_ok || qb_ok || ana_ev);
   always_comb begin
      ev_cw = !code_r[7];
      if (step_ev)
         ev_cw = a_s;
      else if (qa_ok)
         ev_cw = (a_s != b_s);
      else if (qb_ok)
         ev_cw = (b_s == a_s);
   end
   // Only one request is held, so bursts collapse to the capped rate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_r <= 1'b0;
         pend_cw_r <= 1'b0;
      end else if (ev) begin
         pend_r <= 1'b1;
         pend_cw_r <= ev_cw;
      end else if (fire || !idle_s) begin
         pend_r <= 1'b0;
      end
   end

   // ****************************************
   // Pulse scheduler and output
   // ****************************************
   localparam logic [31:0] GAP_LD = 32'(GAP_CYC - 1);
   localparam logic [31:0] PW_LD = 32'(mpd_pkg::PULSE_CYC - 1);
   logic [31:0] gap_cnt_r;
   logic [31:0] pw_cnt_r;
   logic en_r;
   logic shut_r;
   logic warn_r;
   logic [31:0] cnt_r;
   assign fire = pend_r && idle_s && en_r && !shut_r && !pulse_out
                 && (gap_cnt_r == 32'h0);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         gap_cnt_r <= 32'h0;
      else if (fire)
         gap_cnt_r <= GAP_LD;
      else if (gap_cnt_r != 32'h0)
         gap_cnt_r <= gap_cnt_r - 32'h1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_out <= 1'b0;
         pulse_cw <= 1'b0;
         green_led <= 1'b1;
         pw_cnt_r <= 32'h0;
      end else if (fire) begin
         pulse_out <= 1'b1;
         pulse_cw <= pend_cw_r;
         green_led <= 1'b0;
         pw_cnt_r <= PW_LD;
      end else if (pulse_out) begin
         if (pw_cnt_r == 32'h0) begin
            pulse_out <= 1'b0;
            green_led <= 1'b1;
         end else begin
            pw_cnt_r <= pw_cnt_r - 32'h1;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cnt_r <= 32'h0;
      else if (fire)
         cnt_r <= cnt_r + 32'h1;
   end

   // ****************************************
   // Temperature supervision
   // ****************************************
   mpd_pkg::mpd_thr_t thr_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         warn_r <= 1'b0;
         shut_r <= 1'b0;
      end else if (temp_valid) begin
         warn_r <= (temp_code >= thr_r.warn);
         if (temp_code >= thr_r.shut)
            shut_r <= 1'b1;
         else if (temp_code <= thr_r.rec)
            shut_r <= 1'b0;
      end
   end

   // ****************************************
   // Revision flash, then fault indication
   // ****************************************
   logic [31:0] ms_cnt_r;
   logic ms_tick;
   mpd_pkg::mpd_fl_t fl_r;
   logic [11:0] fl_cnt_r;
   logic [3:0] fl_num_r;
   logic fl_minor_r;
   logic fl_step;
   assign ms_tick = (ms_cnt_r == 32'(MS_CYC - 1));
   assign fl_step = ms_tick && (fl_cnt_r == 12'h0);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ms_cnt_r <= 32'h0;
      else if (ms_tick)
         ms_cnt_r <= 32'h0;
      else
         ms_cnt_r <= ms_cnt_r + 32'h1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fl_r <= mpd_pkg::FL_LEAD;
         fl_cnt_r <= 12'(mpd_pkg::FL_LEAD_MS - 1);
         fl_num_r <= 4'h0;
         fl_minor_r <= 1'b0;
      end else if (ms_tick && fl_cnt_r != 12'h0) begin
         fl_cnt_r <= fl_cnt_r - 12'h1;
      end else if (fl_step) begin
         case (fl_r)
            mpd_pkg::FL_LEAD, mpd_pkg::FL_PAUSE: begin
               fl_num_r <= fl_minor_r ? FW_MINOR - 4'h1 : FW_MAJOR - 4'h1;
               fl_cnt_r <= 12'(mpd_pkg::FL_ON_MS - 1);
               fl_r <= mpd_pkg::FL_ON;
               if ((fl_minor_r ? FW_MINOR : FW_MAJOR) == 4'h0) begin
                  fl_r <= fl_minor_r ? mpd_pkg::FL_DONE : mpd_pkg::FL_PAUSE;
                  fl_cnt_r <= 12'(mpd_pkg::FL_PAUSE_MS - 1);
                  fl_minor_r <= 1'b1;
               end
            end
            mpd_pkg::FL_ON: begin
               fl_r <= mpd_pkg::FL_OFF;
               fl_cnt_r <= 12'(mpd_pkg::FL_OFF_MS - 1);
            end
            mpd_pkg::FL_OFF: begin
               if (fl_num_r != 4'h0) begin
                  fl_num_r <= fl_num_r - 4'h1;
                  fl_r <= mpd_pkg::FL_ON;
                  fl_cnt_r <= 12'(mpd_pkg::FL_ON_MS - 1);
               end else if (!fl_minor_r) begin
                  fl_minor_r <= 1'b1;
                  fl_r <= mpd_pkg::FL_PAUSE;
                  fl_cnt_r <= 12'(mpd_pkg::FL_PAUSE_MS - 1);
               end else begin
                  fl_r <= mpd_pkg::FL_DONE;
               end
            end
            mpd_pkg::FL_DONE: fl_r <= mpd_pkg::FL_DONE;
            default: fl_r <= mpd_pkg::FL_DONE;
         endcase
      end
   end
   logic red_nxt;
   assign red_nxt = (fl_r == mpd_pkg::FL_DONE) ? (warn_r || shut_r)
                                                : (fl_r == mpd_pkg::FL_ON);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         red_led <= 1'b0;
         fault_out_n <= 1'b1;
      end else begin
         red_led <= red_nxt;
         fault_out_n <= !red_nxt;
      end
   end

   // ****************************************
   // APB slave, zero wait states
   // ****************************************
   mpd_pkg::mpd_stat_t stat;
   assign stat = '{pend: pend_r, idle: !idle_s, flash: (fl_r != mpd_pkg::FL_DONE),
                   shut: shut_r, warn: warn_r, lock: lock_r, mode: mode_r};
   logic wr;
   assign wr = psel && penable && pwrite;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_r <= mpd_pkg::CTRL_EN_RST;
         thr_r <= '{rec: mpd_pkg::REC_RST, shut: mpd_pkg::SHUT_RST, warn: mpd_pkg::WARN_RST};
      end else if (wr && paddr == mpd_pkg::CTRL_OFS) begin
         en_r <= pwdata[mpd_pkg::CTRL_EN_BIT];
      end else if (wr && paddr == mpd_pkg::THR_OFS) begin
         thr_r <= pwdata[23:0];
      end
   end
   // Read data and error are formed in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pslverr <= 1'b0;
         pready <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (psel && !penable) begin
            pslverr <= 1'b0;
            prdata <= 32'h0;
            case (paddr)
               mpd_pkg::CTRL_OFS: prdata <= {31'h0, en_r};
               mpd_pkg::THR_OFS: prdata <= {8'h00, thr_r};
               mpd_pkg::STAT_OFS: prdata <= {24'h0, stat};
               mpd_pkg::CNT_OFS: prdata <= cnt_r;
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_mode_fixed;
      lock_r |=> lock_r && $stable(mode_r);
   endproperty
   a_mode_fixed: assert property (p_mode_fixed) else $error("mode changed after lock");

   property p_mode_decode;
      $rose(lock_r) |-> mode_r == mpd_pkg::mpd_mode_t'($past(sync2_r[3:2]));
   endproperty
   a_mode_decode: assert property (p_mode_decode) else $error("strap decode wrong");

   property p_step_pend;
      lock_r && step_ev && idle_s |=> pend_r && pend_cw_r == $past(a_s);
   endproperty
   a_step_pend: assert property (p_step_pend) else $error("step edge lost");

   property p_gap;
      fire |=> !fire [*8] ##0 (gap_cnt_r == GAP_LD - 32'h7);
   endproperty
   a_gap: assert property (p_gap) else $error("pulse spacing short");

   property p_green;
      pulse_out |-> !green_led;
   endproperty
   a_green: assert property (p_green) else $error("green lit during pulse");

   property p_shut;
      shut_r |-> !fire;
   endproperty
   a_shut: assert property (p_shut) else $error("pulse while shut down");

   property p_warn;
      fl_r == mpd_pkg::FL_DONE && warn_r |=> !fault_out_n && red_led;
   endproperty
   a_warn: assert property (p_warn) else $error("warning not shown");

   property p_idle;
      !idle_s |=> !pend_r || $past(ev);
   endproperty
   a_idle: assert property (p_idle) else $error("request kept while idle");

   property p_chatter;
      qany_r && !qlast_b_r && ea |-> !qa_ok;
   endproperty
   a_chatter: assert property (p_chatter) else $error("repeat edge accepted");

   property p_deadband;
      mag <= mpd_pkg::DB_CODE |-> inc == 9'h000 && !ana_ev;
   endproperty
   a_deadband: assert property (p_deadband) else $error("pulse in deadband");

   c_step: cover property (step_ev ##[1:1000] fire);
   c_quad: cover property (qa_ok ##[1:50] qb_ok);
   c_shut: cover property ($rose(shut_r));
   c_flash: cover property ($rose(fl_r == mpd_pkg::FL_DONE));

endmodule : mpd_cmd_decoder
`default_nettype wire

// >>> design/mpd_pkg.sv
// Constants, types and register map of the motor pulse command decoder
package mpd_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_HZ = 50_000_000;
   localparam int MAX_RATE_HZ = 2000;
   localparam int GAP_CYC = (CLK_HZ + MAX_RATE_HZ - 1) / MAX_RATE_HZ;
   localparam int PULSE_US = 50;
   localparam int PULSE_CYC = (PULSE_US * (CLK_HZ / 1_000_000));
   localparam int MS_CYC = CLK_HZ / 1000;
   localparam int FL_LEAD_MS = 500;
   localparam int FL_ON_MS = 200;
   localparam int FL_OFF_MS = 300;
   localparam int FL_PAUSE_MS = 1000;
   localparam logic [1:0] LOCK_WAIT = 2'h3;

   // ****************************************
   // Analog scale: one code step is 78 mV
   // ****************************************
   localparam int LSB_MV = 78;
   localparam int DB_MV = 1000;
   localparam logic [8:0] DB_CODE = 9'((DB_MV + LSB_MV - 1) / LSB_MV);
   localparam logic [8:0] ANA_FULL = 9'h080;

   // ****************************************
   // Temperature in degrees C per code
   // ****************************************
   localparam logic [7:0] WARN_RST = 8'h50;
   localparam logic [7:0] SHUT_RST = 8'h55;
   localparam logic [7:0] REC_RST = 8'h4B;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] THR_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] CNT_OFS = 8'h0C;
   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RST = 1'b1;

   typedef enum logic [1:0] {MD_STEP, MD_QUAD, MD_LIN, MD_BANG} mpd_mode_t;
   typedef enum logic [2:0] {FL_LEAD, FL_ON, FL_OFF, FL_PAUSE, FL_DONE} mpd_fl_t;

   typedef struct packed {
      logic [7:0] rec;
      logic [7:0] shut;
      logic [7:0] warn;
   } mpd_thr_t;

   typedef struct packed {
      logic pend;
      logic idle;
      logic flash;
      logic shut;
      logic warn;
      logic lock;
      logic [1:0] mode;
   } mpd_stat_t;

endpackage : mpd_pkg

// >>> dv/mpd_host_model.sv
// Host controller model driving step/direction or quadrature phases
`timescale 1ns/1ps
`default_nettype none
module mpd_host_model #(
   parameter int EDGE_GAP = 3000
) (
   input wire logic pclk,
   output logic step_in,
   output logic dir_in
);
   // No earlier fall at start, so the first step need not wait
   realtime last_fall = -1.0e5;

   initial begin
      step_in = 1'b0;
      dir_in = 1'b0;
   end

   // ****************************************
   // Line control
   // ****************************************
   // Only used while the device is held in reset
   task automatic park();
      step_in <= 1'b0;
      dir_in <= 1'b0;
   endtask : park

   // Direction never moves within 100 us of a step fall
   task automatic step(input logic d);
      repeat (20) @(posedge pclk);
      while (dir_in !== d && $realtime - last_fall < 100000.0) @(posedge pclk);
      dir_in <= d;
      step_in <= 1'b1;
      repeat (20) @(posedge pclk);
      step_in <= 1'b0;
      last_fall = $realtime;
   endtask : step

   // Edge spacing is the scaled 500 Hz phase limit
   task automatic quad_edge(input logic on_a);
      repeat (EDGE_GAP) @(posedge pclk);
      if (on_a) dir_in <= ~dir_in;
      else step_in <= ~step_in;
   endtask : quad_edge
endmodule : mpd_host_model
`default_nettype wire

// >>> dv/motor_pulse_command_decoder_tb.sv
// Self-checking bench for the motor pulse command decoder
`timescale 1ns/1ps
`default_nettype none
module motor_pulse_command_decoder_tb;
   localparam int GAP = 2600;
   localparam logic [3:0] MAJ = 4'h1;
   localparam logic [3:0] MIN = 4'h2;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic pready;
   logic pslverr;
   logic err;
   logic [7:0] paddr;
   logic [7:0] adc_code;
   logic [7:0] temp_code;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic [1:0] sel;
   logic idle_in_n;
   logic adc_valid;
   logic temp_valid;
   logic step_in;
   logic dir_in;
   logic pulse_out;
   logic pulse_cw;
   logic green_led;
   logic red_led;
   logic fault_out_n;
   logic prev_p;
   logic prev_r;
   logic last_cw;
   int miscompares = 0;
   int checks_done = 0;
   int cyc = 0;
   int npulse = 0;
   int nred = 0;
   int n0;
   // Far in the past, so the very first pulse passes the spacing check
   realtime last_start = -1.0e6;

   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   mpd_cmd_decoder #(.GAP_CYC(GAP), .MS_CYC(5), .FW_MAJOR(MAJ), .FW_MINOR(MIN)) mpd_cmd_decoder_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .iface_sel_bit0(sel[0]), .iface_sel_bit1(sel[1]), .step_in(step_in), .dir_in(dir_in),
      .idle_in_n(idle_in_n), .adc_valid(adc_valid), .adc_code(adc_code),
      .temp_valid(temp_valid), .temp_code(temp_code), .pulse_out(pulse_out),
      .pulse_cw(pulse_cw), .green_led(green_led), .red_led(red_led), .fault_out_n(fault_out_n));

   mpd_host_model #(.EDGE_GAP(GAP)) mpd_host_model_i (
      .pclk(pclk), .step_in(step_in), .dir_in(dir_in));

   // ****************************************
   // Checking and closing
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : conclude

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 100000) begin
         miscompares++;
         conclude();
      end
   end

   // Pulse and indicator watcher; counts restart with every reset
   always @(posedge pclk) begin
      if (presetn !== 1'b1) begin
         npulse = 0;
         nred = 0;
      end else begin
         if (pulse_out === 1'b1 && prev_p !== 1'b1) begin
            npulse++;
            last_cw = pulse_cw;
            check(green_led, 0);
            check($realtime - last_start >= GAP * 20.0, 1);
            last_start = $realtime;
         end
         if (red_led === 1'b1 && prev_r !== 1'b1) nred++;
      end
      prev_p = pulse_out;
      prev_r = red_led;
   end

   // ****************************************
   // Stimulus tasks
   // ****************************************
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Straps are set here while reset holds, as at power-up
   task automatic reset(input logic [1:0] s);
      presetn <= 1'b0;
      sel <= s;
      mpd_host_model_i.park();
      repeat (2) @(posedge pclk);
      check({pready, green_led, red_led, fault_out_n, pulse_out}, 5'b01010);
      presetn <= 1'b1;
      repeat (12) @(posedge pclk);
      apb(0, 8'h08, 0);
      check(rd[2:0], {1'b1, s});
   endtask : reset

   task automatic expect_n(input int k, input int waits);
      repeat (waits) @(posedge pclk);
      check(npulse - n0, k);
   endtask : expect_n

   task automatic sample(input logic is_temp, input logic [7:0] c);
      @(posedge pclk);
      if (is_temp) temp_code <= c;
      else adc_code <= c;
      temp_valid <= is_temp;
      adc_valid <= !is_temp;
      @(posedge pclk);
      temp_valid <= 1'b0;
      adc_valid <= 1'b0;
   endtask : sample

   // Expected count from the accumulator: one request per 128*GAP of magnitude
   task automatic rate(input logic [7:0] c, input int mag, input int win, input logic cw);
      int e;
      e = win * mag / (128 * GAP);
      sample(0, c);
      if (e == 0) repeat (GAP) @(posedge pclk);
      n0 = npulse;
      repeat (win) @(posedge pclk);
      check(npulse - n0 + (e > 0) >= e && npulse - n0 <= e + (e > 0), 1);
      if (e > 0) check(last_cw, cw);
   endtask : rate

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sel = 2'h0;
      idle_in_n = 1'b1;
      adc_valid = 1'b0;
      adc_code = 8'h00;
      temp_valid = 1'b0;
      temp_code = 8'h14;
      prev_p = 1'b0;
      prev_r = 1'b0;
      last_cw = 1'b0;
      reset(2'h0);
      apb(0, 8'h04, 0);
      check(rd, 32'h004B5550);
      apb(1, 8'h10, 32'h5);
      check({err, rd[7:0]}, 9'h100);
      apb(1, 8'h00, 0);
      apb(0, 8'h00, 0);
      check(rd[0], 0);
      apb(1, 8'h00, 1);
      n0 = npulse;
      mpd_host_model_i.step(1);
      expect_n(1, GAP);
      check(last_cw, 1);
      n0 = npulse;
      mpd_host_model_i.step(1);
      mpd_host_model_i.step(1);
      expect_n(2, 2 * GAP + 100);
      n0 = npulse;
      mpd_host_model_i.step(0);
      expect_n(1, GAP);
      check(last_cw, 0);
      apb(0, 8'h0C, 0);
      check(rd, 4);
      sel <= 2'h3;
      apb(0, 8'h08, 0);
      check(rd[1:0], 0);
      idle_in_n <= 1'b0;
      n0 = npulse;
      mpd_host_model_i.step(0);
      repeat (2 * GAP) @(posedge pclk);
      check(npulse - n0 <= 1, 1);
      idle_in_n <= 1'b1;
      n0 = npulse;
      mpd_host_model_i.step(0);
      expect_n(1, GAP);
      $display("step mode test done");
      rd = 32'hFFFF_FFFF;
      while (rd[5] !== 1'b0) begin
         repeat (1000) @(posedge pclk);
         apb(0, 8'h08, 0);
      end
      check(nred, MAJ + MIN);
      check({red_led, fault_out_n}, 2'b01);
      sample(1, 8'h50);
      repeat (5) @(posedge pclk);
      check({red_led, fault_out_n}, 2'b10);
      n0 = npulse;
      mpd_host_model_i.step(0);
      expect_n(1, GAP);
      sample(1, 8'h55);
      n0 = npulse;
      mpd_host_model_i.step(0);
      expect_n(0, GAP);
      sample(1, 8'h50);
      expect_n(0, GAP);
      sample(1, 8'h4B);
      expect_n(1, 20);
      check(fault_out_n, 1);
      $display("temperature test done");
      reset(2'h1);
      n0 = npulse;
      mpd_host_model_i.quad_edge(1);
      mpd_host_model_i.quad_edge(0);
      mpd_host_model_i.quad_edge(1);
      mpd_host_model_i.quad_edge(0);
      expect_n(4, 100);
      check(last_cw, 1);
      n0 = npulse;
      mpd_host_model_i.quad_edge(1);
      mpd_host_model_i.quad_edge(1);
      expect_n(1, 100);
      n0 = npulse;
      mpd_host_model_i.quad_edge(0);
      mpd_host_model_i.quad_edge(1);
      expect_n(2, 100);
      check(last_cw, 0);
      $display("quadrature test done");
      reset(2'h2);
      rate(8'h0D, 13, 3000, 1);
      rate(8'h40, 64, 12000, 1);
      rate(8'h80, 128, 6000, 0);
      $display("linear test done");
      reset(2'h3);
      rate(8'h0E, 128, 6000, 1);
      rate(8'hF2, 128, 6000, 0);
      rate(8'hF3, 0, 3000, 0);
      $display("bang-bang test done");
      conclude();
   end
endmodule : motor_pulse_command_decoder_tb
`default_nettype wire
